// *** logic/fxo_pkg.sv ***
// fxo_pkg: shared types and constants of the fp operand-error / overflow exception unit
// assumes: an 80-bit extended register format (sign, 15-bit exponent, 64-bit mantissa)
package fxo_pkg;

  // ==========================================================================
  // encodings
  typedef enum logic [1:0] {DEST_FPREG = 2'h0, DEST_MEM = 2'h1, DEST_INTREG = 2'h2} fxo_dest_type;
  typedef enum logic [2:0] {
    FMT_LONG = 3'h0, FMT_SGL = 3'h1, FMT_EXT = 3'h2, FMT_PACK = 3'h3,
    FMT_WORD = 3'h4, FMT_DBL = 3'h5, FMT_BYTE = 3'h6
  } fxo_fmt_type;
  typedef enum logic [1:0] {PREC_EXT = 2'h0, PREC_SGL = 2'h1, PREC_DBL = 2'h2} fxo_prec_type;
  typedef enum logic [1:0] {
    RMODE_NEAREST = 2'h0, RMODE_ZERO = 2'h1, RMODE_MINUS = 2'h2, RMODE_PLUS = 2'h3
  } fxo_rmode_type;
  typedef enum logic [1:0] {
    TGT_RESUME = 2'h0, TGT_USER_INEX = 2'h1, TGT_USER_OPERAND_ERROR_FLAG = 2'h2, TGT_USER_OVERFLOW_FLAG = 2'h3
  } fxo_target_type;
  typedef enum logic [1:0] {EXC_NONE = 2'h0, EXC_OPERAND_ERROR_FLAG = 2'h1, EXC_CONV = 2'h2, EXC_OVERFLOW_FLAG = 2'h3} fxo_exc_type;

  // ==========================================================================
  // exponent limits (unbiased, intermediate 16-bit exponent)
  localparam logic signed [15:0] EXP_MAX_SGL = 16'sh0080;
  localparam logic signed [15:0] EXP_MAX_DBL = 16'sh0400;
  localparam logic signed [15:0] EXP_MAX_EXT = 16'sh4000;
  localparam logic signed [15:0] EXP_MIN_SGL = 16'shff82;
  localparam logic signed [15:0] EXP_MIN_DBL = 16'shfc02;
  localparam logic signed [15:0] EXP_MIN_EXT = 16'shc002;

  // ==========================================================================
  // default result values
  localparam logic [14:0] EXT_EXP_INF = 15'h7fff;
  localparam logic [14:0] LGST_EXP_SGL = 15'h407e;
  localparam logic [14:0] LGST_EXP_DBL = 15'h43fe;
  localparam logic [14:0] LGST_EXP_EXT = 15'h7ffe;
  localparam logic [63:0] MANT_INF = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MANT_ONES_SGL = 64'hffff_ff00_0000_0000;
  localparam logic [63:0] MANT_ONES_DBL = 64'hffff_ffff_ffff_f800;
  localparam logic [63:0] MANT_ONES_EXT = 64'hffff_ffff_ffff_ffff;
  localparam logic [79:0] QNAN_ALL_ONES = 80'h7fff_ffff_ffff_ffff_ffff;
  localparam logic [31:0] INT_MIN_BYTE = 32'hffff_ff80;
  localparam logic [31:0] INT_MAX_BYTE = 32'h0000_007f;
  localparam logic [31:0] INT_MIN_WORD = 32'hffff_8000;
  localparam logic [31:0] INT_MAX_WORD = 32'h0000_7fff;
  localparam logic [31:0] INT_MIN_LONG = 32'h8000_0000;
  localparam logic [31:0] INT_MAX_LONG = 32'h7fff_ffff;

  // ==========================================================================
  // one finished operation as it leaves the arithmetic pipeline
  typedef struct packed {
    fxo_dest_type destKind;
    fxo_fmt_type destFmt;
    logic sign;
    logic signed [15:0] exp;
    logic roundCarry;
    logic operand_error_flag;
    logic convTooLarge;
    logic convNan;
    logic convInf;
    logic convMostNeg;
    logic depMove;
    logic moveOut;
    logic expFamily;
    logic forced;
    fxo_prec_type forcedSel;
    logic [31:0] instrAddr;
    logic [31:0] effAddr;
  } fxo_op_type;

endpackage

// *** logic/fxo_res_if.sv ***
// fxo_res_if: carries the default-result request and answers between the unit and its helpers
// assumes: purely combinational helpers on the far side
`timescale 1ns/10ps
interface fxo_res_if;
  import fxo_pkg::*;
  logic sign;
  fxo_rmode_type roundMode;
  fxo_prec_type prec;
  fxo_fmt_type intFmt;
  logic mostNeg;
  logic [79:0] ovflValue;
  logic [31:0] intValue;
  modport ctl (output sign, roundMode, prec, intFmt, mostNeg, input ovflValue, intValue);
  modport overflow_flag (input sign, roundMode, prec, output ovflValue);
  modport sat (input sign, intFmt, mostNeg, output intValue);
endinterface

// *** logic/fxo_overflow_flag_value.sv ***
// fxo_overflow_flag_value: overflow default result by rounding mode and precision
// assumes: sign, mode and precision stable while the answer is used
`timescale 1ns/10ps
module fxo_overflow_flag_value import fxo_pkg::*; (
  fxo_res_if.overflow_flag res
);
  logic [14:0] lgExp;
  logic [63:0] lgMant;
  logic useInf;

  // ==========================================================================
  // largest magnitude of the precision, or infinity
  always_comb begin
    unique case (res.prec)
      PREC_SGL: begin
        lgExp = LGST_EXP_SGL;
        lgMant = MANT_ONES_SGL;
      end
      PREC_DBL: begin
        lgExp = LGST_EXP_DBL;
        lgMant = MANT_ONES_DBL;
      end
      default: begin
        lgExp = LGST_EXP_EXT;
        lgMant = MANT_ONES_EXT;
      end
    endcase
    unique case (res.roundMode)
      RMODE_NEAREST: useInf = 1'h1;
      RMODE_ZERO: useInf = 1'h0;
      RMODE_MINUS: useInf = res.sign;
      RMODE_PLUS: useInf = ~res.sign;
    endcase
    res.ovflValue = useInf ? {res.sign, EXT_EXP_INF, MANT_INF} : {res.sign, lgExp, lgMant};
  end
endmodule // fxo_overflow_flag_value

// *** logic/fxo_int_sat.sv ***
// fxo_int_sat: integer default result for failed conversions
// assumes: intFmt is byte, word or long
`timescale 1ns/10ps
module fxo_int_sat import fxo_pkg::*; (
  fxo_res_if.sat res
);
  logic useMin;

  // ==========================================================================
  // most negative for the erroneous case or negative overflow, else most positive
  always_comb begin
    useMin = res.mostNeg | res.sign;
    unique case (res.intFmt)
      FMT_BYTE: res.intValue = useMin ? INT_MIN_BYTE : INT_MAX_BYTE;
      FMT_WORD: res.intValue = useMin ? INT_MIN_WORD : INT_MAX_WORD;
      default: res.intValue = useMin ? INT_MIN_LONG : INT_MAX_LONG;
    endcase
  end
endmodule // fxo_int_sat

// *** logic/fxo_exc_unit.sv ***
// fxo_exc_unit: operand-error and overflow detection, reporting and default results
// assumes: the pipeline stalls while busy is high; fpIssue pulses once per fp instruction
//
// What this block does
// - masked operand error stores all-ones quiet NaN, no exception, continue.
// - unmasked operand error keeps destination, posts, pre-instruction on next fp instr.
// - bad conversion to byte/word/long takes an immediate post-instruction exception.
// - erroneous most-negative conversion stores that width's most negative value.
// - conversion overflow or infinity stores largest integer of matching sign.
// - overflow when intermediate exponent reaches precision's maximum exponent.
// - overflow only for single/double/extended; other formats become operand error.
// - underflow check, then round, then overflow check, then store.
// - overflow flag set always takes the nonmaskable overflow exception.
// - fp register destination: pre-instruction on next fp instr; memory/integer gets post-instruction at once.
// - overflow result follows rounding mode table.
// - overflow result precision: control, destination format, or forced.
// - overflow with dependent move reports post-instruction; address field invalid.
// - move-out overflow frame address field holds destination memory address.
// - integer register destination: instruction address points at the instruction.
// - exponential family overflow marks intermediate frame fields invalid.
// - overflow masked: go to inexact handler if inexact and enabled, else resume.
// - overflow unmasked: continue at user overflow handler.
// - any operand error sets the operand-error flag.
`timescale 1ns/10ps
module fxo_exc_unit import fxo_pkg::*; (
  input logic clk_sys,
  input logic rst,
  input logic opValid,
  input fxo_dest_type destKind,
  input fxo_fmt_type destFmt,
  input logic resSign,
  input logic signed [15:0] resExp,
  input logic roundCarry,
  input logic opErrCond,
  input logic convTooLarge,
  input logic convNan,
  input logic convInf,
  input logic convMostNeg,
  input logic depMove,
  input logic moveOut,
  input logic expFamily,
  input logic forcedPrec,
  input fxo_prec_type forcedPrecSel,
  input logic [31:0] instrAddr,
  input logic [31:0] effAddr,
  input fxo_rmode_type roundMode,
  input fxo_prec_type roundPrec,
  input logic userOperrEn,
  input logic userOvflEn,
  input logic userInexEn,
  input logic inexactInputFlag,
  input logic inexactResultFlag,
  input logic fpIssue,
  input logic excByteClear,
  output logic busy_r,
  output logic operandErrorFlag_r,
  output logic overflowFlag_r,
  output logic underflowSeen_r,
  output logic destWrite_r,
  output logic [79:0] destValue_r,
  output logic intWrite_r,
  output logic [31:0] intValue_r,
  output logic excPre_r,
  output logic excPost_r,
  output fxo_exc_type excKind_r,
  output logic handlerGo_r,
  output fxo_target_type handlerTarget_r,
  output logic frameEaValid_r,
  output logic [31:0] frameEa_r,
  output logic [31:0] frameInstrAddr_r,
  output logic frameIntermedValid_r
);

  // ==========================================================================
  // state
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_PEND = 3'h2, S_SUPP = 3'h4} fxo_fsm_type;
  typedef struct packed {
    fxo_fsm_type fsm;
    logic aV;
    fxo_op_type aOp;
    logic bV;
    fxo_op_type bOp;
    logic cV;
    fxo_op_type cOp;
    logic cOvfl;
    fxo_exc_type hKind;
    fxo_op_type hOp;
    logic operandErrorFlag;
    logic overflowFlag;
    logic underflowSeen;
    logic destWrite;
    logic [79:0] destValue;
    logic intWrite;
    logic [31:0] intValue;
    logic excPre;
    logic excPost;
    logic handlerGo;
    fxo_target_type handlerTarget;
    logic frameEaValid;
    logic [31:0] frameEa;
    logic [31:0] frameInstrAddr;
    logic frameIntermedValid;
    logic busy;
  } fxo_state_type;

  fxo_state_type st_r;
  fxo_state_type st_nxt;
  fxo_op_type inOp;
  fxo_res_if res ();
  logic cTake;
  logic intFmt;
  logic fpFmt;
  logic convErr;
  logic opErrSel;
  logic ovflSel;
  logic inexGo;

  fxo_overflow_flag_value u_overflow_flag (.res(res.overflow_flag));
  fxo_int_sat u_sat (.res(res.sat));

  // ==========================================================================
  // helpers
  function automatic fxo_prec_type effPrec(input fxo_op_type op, input fxo_prec_type ctl);
    if (op.forced) begin
      effPrec = op.forcedSel;
    end else if (op.destKind == DEST_FPREG) begin
      effPrec = ctl;
    end else if (op.destFmt == FMT_SGL) begin
      effPrec = PREC_SGL;
    end else if (op.destFmt == FMT_DBL) begin
      effPrec = PREC_DBL;
    end else begin
      effPrec = PREC_EXT;
    end
  endfunction

  function automatic logic isIntFmt(input fxo_fmt_type f);
    isIntFmt = (f == FMT_BYTE) || (f == FMT_WORD) || (f == FMT_LONG);
  endfunction

  // ==========================================================================
  // combinational
  always_comb begin
    inOp = '{destKind: destKind, destFmt: destFmt, sign: resSign, exp: resExp,
      roundCarry: roundCarry, operand_error_flag: opErrCond, convTooLarge: convTooLarge,
      convNan: convNan, convInf: convInf, convMostNeg: convMostNeg, depMove: depMove,
      moveOut: moveOut, expFamily: expFamily, forced: forcedPrec,
      forcedSel: forcedPrecSel, instrAddr: instrAddr, effAddr: effAddr};
    res.sign = st_r.hOp.sign;
    res.roundMode = roundMode;
    res.prec = effPrec(st_r.hOp, roundPrec);
    res.intFmt = st_r.hOp.destFmt;
    res.mostNeg = st_r.hOp.convMostNeg;
    cTake = st_r.cV && (st_r.fsm == S_IDLE);
    intFmt = isIntFmt(st_r.cOp.destFmt);
    fpFmt = (st_r.cOp.destFmt == FMT_SGL) || (st_r.cOp.destFmt == FMT_DBL)
      || (st_r.cOp.destFmt == FMT_EXT);
    convErr = intFmt && (st_r.cOp.convTooLarge || st_r.cOp.convNan || st_r.cOp.convInf
      || st_r.cOp.convMostNeg || st_r.cOvfl);
    opErrSel = !convErr && (st_r.cOp.operand_error_flag || (st_r.cOvfl && !fpFmt));
    ovflSel = !convErr && !opErrSel && st_r.cOvfl && fpFmt;
    inexGo = userInexEn && (inexactInputFlag || inexactResultFlag);

    st_nxt = st_r;
    st_nxt.destWrite = 1'h0;
    st_nxt.intWrite = 1'h0;
    st_nxt.excPre = 1'h0;
    st_nxt.excPost = 1'h0;
    st_nxt.handlerGo = 1'h0;
    if (excByteClear) begin
      st_nxt.operandErrorFlag = 1'h0;
      st_nxt.overflowFlag = 1'h0;
      st_nxt.underflowSeen = 1'h0;
    end

    // pipeline: underflow check, round, overflow check
    st_nxt.aV = opValid;
    if (opValid) begin
      st_nxt.aOp = inOp;
    end
    st_nxt.bV = st_r.aV;
    if (st_r.aV) begin
      if (st_r.aOp.exp <= ((effPrec(st_r.aOp, roundPrec) == PREC_SGL) ? EXP_MIN_SGL :
          (effPrec(st_r.aOp, roundPrec) == PREC_DBL) ? EXP_MIN_DBL : EXP_MIN_EXT)) begin
        st_nxt.underflowSeen = 1'h1;
      end
      st_nxt.bOp = st_r.aOp;
      st_nxt.bOp.exp = st_r.aOp.exp + {15'h0000, st_r.aOp.roundCarry};
    end
    st_nxt.cV = st_r.bV;
    if (st_r.bV) begin
      st_nxt.cOp = st_r.bOp;
      st_nxt.cOvfl = st_r.bOp.exp >= ((effPrec(st_r.bOp, roundPrec) == PREC_SGL) ? EXP_MAX_SGL :
        (effPrec(st_r.bOp, roundPrec) == PREC_DBL) ? EXP_MAX_DBL : EXP_MAX_EXT);
    end

    unique case (st_r.fsm)
      S_IDLE: begin
        if (cTake && (convErr || opErrSel || ovflSel)) begin
          st_nxt.hOp = st_r.cOp;
          st_nxt.frameInstrAddr = st_r.cOp.instrAddr;
          st_nxt.frameEa = st_r.cOp.effAddr;
          st_nxt.frameEaValid = st_r.cOp.moveOut && (st_r.cOp.destKind == DEST_MEM);
          st_nxt.frameIntermedValid = !(ovflSel && st_r.cOp.expFamily);
        end
        if (cTake && convErr) begin
          st_nxt.operandErrorFlag = 1'h1;
          st_nxt.hKind = EXC_CONV;
          st_nxt.excPost = 1'h1;
          st_nxt.fsm = S_SUPP;
        end else if (cTake && opErrSel) begin
          st_nxt.operandErrorFlag = 1'h1;
          st_nxt.hKind = EXC_OPERAND_ERROR_FLAG;
          if (!userOperrEn) begin
            st_nxt.destWrite = 1'h1;
            st_nxt.destValue = QNAN_ALL_ONES;
          end else begin
            st_nxt.fsm = S_PEND;
          end
        end else if (cTake && ovflSel) begin
          st_nxt.overflowFlag = 1'h1;
          st_nxt.hKind = EXC_OVERFLOW_FLAG;
          if ((st_r.cOp.destKind == DEST_FPREG) && !st_r.cOp.depMove) begin
            st_nxt.fsm = S_PEND;
          end else begin
            st_nxt.excPost = 1'h1;
            st_nxt.fsm = S_SUPP;
          end
        end
      end
      S_PEND: begin
        if (fpIssue) begin
          st_nxt.excPre = 1'h1;
          st_nxt.fsm = S_SUPP;
        end
      end
      S_SUPP: begin
        st_nxt.handlerGo = 1'h1;
        st_nxt.fsm = S_IDLE;
        unique case (st_r.hKind)
          EXC_CONV: begin
            st_nxt.intWrite = !st_r.hOp.convNan;
            st_nxt.intValue = res.intValue;
            st_nxt.handlerTarget = userOperrEn ? TGT_USER_OPERAND_ERROR_FLAG :
              (inexGo ? TGT_USER_INEX : TGT_RESUME);
          end
          EXC_OVERFLOW_FLAG: begin
            st_nxt.destWrite = 1'h1;
            st_nxt.destValue = res.ovflValue;
            st_nxt.handlerTarget = userOvflEn ? TGT_USER_OVERFLOW_FLAG :
              (inexGo ? TGT_USER_INEX : TGT_RESUME);
          end
          default: begin
            st_nxt.handlerTarget = TGT_USER_OPERAND_ERROR_FLAG;
          end
        endcase
      end
    endcase
    st_nxt.busy = (st_nxt.fsm != S_IDLE);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.fsm <= S_IDLE;
      st_r.frameIntermedValid <= 1'h1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_r = st_r.busy;
  assign operandErrorFlag_r = st_r.operandErrorFlag;
  assign overflowFlag_r = st_r.overflowFlag;
  assign underflowSeen_r = st_r.underflowSeen;
  assign destWrite_r = st_r.destWrite;
  assign destValue_r = st_r.destValue;
  assign intWrite_r = st_r.intWrite;
  assign intValue_r = st_r.intValue;
  assign excPre_r = st_r.excPre;
  assign excPost_r = st_r.excPost;
  assign excKind_r = st_r.hKind;
  assign handlerGo_r = st_r.handlerGo;
  assign handlerTarget_r = st_r.handlerTarget;
  assign frameEaValid_r = st_r.frameEaValid;
  assign frameEa_r = st_r.frameEa;
  assign frameInstrAddr_r = st_r.frameInstrAddr;
  assign frameIntermedValid_r = st_r.frameIntermedValid;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_nan_store;
    cTake && opErrSel && !userOperrEn |=> destWrite_r && destValue_r == QNAN_ALL_ONES
      && !excPre_r && !excPost_r ##1 !handlerGo_r;
  endproperty
  a_nan_store: assert property (p_nan_store) else $error("masked operand error result wrong");

  property p_operand_error_flag_pend;
    cTake && opErrSel && userOperrEn |=> !destWrite_r && st_r.fsm == S_PEND;
  endproperty
  a_operand_error_flag_pend: assert property (p_operand_error_flag_pend) else $error("operand error not posted");

  property p_conv_post;
    cTake && convErr |=> excPost_r && operandErrorFlag_r ##1 handlerGo_r;
  endproperty
  a_conv_post: assert property (p_conv_post) else $error("conversion error not immediate");

  property p_min_byte;
    st_r.fsm == S_SUPP && st_r.hKind == EXC_CONV && st_r.hOp.convMostNeg
      && st_r.hOp.destFmt == FMT_BYTE |=> intWrite_r && intValue_r == INT_MIN_BYTE;
  endproperty
  a_min_byte: assert property (p_min_byte) else $error("most negative byte not stored");

  property p_overflow_flag_taken;
    cTake && ovflSel |=> overflowFlag_r ##[0:1] (excPost_r || st_r.fsm == S_PEND);
  endproperty
  a_overflow_flag_taken: assert property (p_overflow_flag_taken) else $error("overflow exception not taken");

  property p_dep_post;
    cTake && ovflSel && st_r.cOp.depMove && !st_r.cOp.moveOut
      |=> excPost_r && !frameEaValid_r;
  endproperty
  a_dep_post: assert property (p_dep_post) else $error("dependent overflow not posted");

  property p_pend_hold;
    st_r.fsm == S_PEND && !fpIssue |=> st_r.fsm == S_PEND && !excPre_r;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("pending exception left early");

  property p_overflow_flag_user;
    st_r.fsm == S_SUPP && st_r.hKind == EXC_OVERFLOW_FLAG && userOvflEn
      |=> handlerGo_r && handlerTarget_r == TGT_USER_OVERFLOW_FLAG && destWrite_r;
  endproperty
  a_overflow_flag_user: assert property (p_overflow_flag_user) else $error("overflow handler target wrong");

  property p_exp_family;
    cTake && ovflSel && st_r.cOp.expFamily |=> !frameIntermedValid_r;
  endproperty
  a_exp_family: assert property (p_exp_family) else $error("intermediate marked valid");

  c_pre: cover property (st_r.fsm == S_PEND ##[1:20] excPre_r);
  c_post_conv: cover property (cTake && convErr ##1 excPost_r ##1 intWrite_r);
  c_nan: cover property (cTake && opErrSel && !userOperrEn ##1 destWrite_r);
  c_inex: cover property (handlerGo_r && handlerTarget_r == TGT_USER_INEX);

endmodule // fxo_exc_unit

// *** testbench/fxo_pipe_model.sv ***
// fxo_pipe_model: pipeline and handler software stand-in
// assumes: issues the next fp instruction after issueDelay+1 busy cycles
`timescale 1ns/10ps
module fxo_pipe_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic busy_r,
  input wire logic [3:0] issueDelay,
  output logic fpIssue
);
  logic [3:0] waitCnt;
  // ======
  // next fp instr: pulse fpIssue after issueDelay+1 busy cycles, clear the count to zero when idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      waitCnt <= 4'h0;
      fpIssue <= 1'b0;
    end else begin
      fpIssue <= busy_r && (waitCnt == issueDelay);
      waitCnt <= busy_r ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule // fxo_pipe_model

// *** testbench/fxo_exc_unit_tb.sv ***
// fxo_exc_unit_tb: self-checking bench of the exception unit
// assumes: fxo_pipe_model answers pending exceptions
`timescale 1ns/10ps
module fxo_exc_unit_tb;
  import fxo_pkg::*;
  logic clk_sys, rst, opValid, exClr, fpIssue, busy_r, opErrF, ovF, operrEn, ovflEn, inexEn;
  logic inexIn, inexRes, destWrite_r, intWrite_r, excPre_r, excPost_r, eaValid, unF, goF, imValid;
  logic [79:0] destValue_r;
  logic [31:0] intValue_r, frameEa_r, iaddr;
  logic [3:0] issueDelay;
  fxo_op_type op;
  fxo_rmode_type rMode;
  fxo_prec_type rPrec;
  fxo_exc_type excKind_r;
  fxo_target_type tgt;
  int miscompares, cmp_count, seenPre, seenPost, seenDest, seenGo, seenInt;
  // ======
  fxo_exc_unit i_dut (.clk_sys, .rst, .opValid, .destKind(op.destKind), .destFmt(op.destFmt),
    .resSign(op.sign), .resExp(op.exp), .roundCarry(op.roundCarry), .opErrCond(op.operand_error_flag),
    .convTooLarge(op.convTooLarge), .convNan(op.convNan), .convInf(op.convInf),
    .convMostNeg(op.convMostNeg), .depMove(op.depMove), .moveOut(op.moveOut),
    .expFamily(op.expFamily), .forcedPrec(op.forced), .forcedPrecSel(op.forcedSel),
    .instrAddr(op.instrAddr), .effAddr(op.effAddr), .roundMode(rMode), .roundPrec(rPrec),
    .userOperrEn(operrEn), .userOvflEn(ovflEn), .userInexEn(inexEn),
    .inexactInputFlag(inexIn), .inexactResultFlag(inexRes), .fpIssue, .excByteClear(exClr),
    .busy_r, .operandErrorFlag_r(opErrF), .overflowFlag_r(ovF), .underflowSeen_r(unF),
    .destWrite_r, .destValue_r, .intWrite_r, .intValue_r, .excPre_r, .excPost_r, .excKind_r,
    .handlerGo_r(goF), .handlerTarget_r(tgt), .frameEaValid_r(eaValid), .frameEa_r,
    .frameInstrAddr_r(iaddr), .frameIntermedValid_r(imValid));
  fxo_pipe_model i_pipe (.clk_sys, .rst, .busy_r, .issueDelay, .fpIssue);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    seenPre += int'(excPre_r === 1'b1);
    seenPost += int'(excPost_r === 1'b1);
    seenDest += int'(destWrite_r === 1'b1);
    seenGo += int'(goF === 1'b1);
    seenInt += int'(intWrite_r === 1'b1);
  end
  // ======
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk80(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    chk80(80'(got), 80'(exp));
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic newOp(input fxo_dest_type k, input fxo_fmt_type f);
    op = '0;
    op.destKind = k;
    op.destFmt = f;
    op.sign = 1'($urandom);
    op.exp = 16'sh0010;
    op.instrAddr = $urandom;
    op.effAddr = $urandom;
  endtask
  task automatic runOp(input int dly);
    int n;
    issueDelay = 4'(dly);
    {seenPre, seenPost, seenDest, seenGo, seenInt} = '0;
    exClr = 1'b1;
    tick();
    exClr = 1'b0;
    opValid = 1'b1;
    tick();
    opValid = 1'b0;
    tick(4);
    for (n = 0; n < 40 && busy_r !== 1'b0; n++) begin
      tick();
    end
    tick(2);
    if (n == 40) begin
      miscompares++;
      stop_test();
    end
  endtask
  function automatic logic [31:0] intExp(input fxo_fmt_type f, input logic neg);
    case (f)
      FMT_BYTE: return neg ? INT_MIN_BYTE : INT_MAX_BYTE;
      FMT_WORD: return neg ? INT_MIN_WORD : INT_MAX_WORD;
      default: return neg ? INT_MIN_LONG : INT_MAX_LONG;
    endcase
  endfunction
  function automatic logic [79:0] ovExp(input logic s, input fxo_rmode_type m, input logic sgl);
    logic big;
    big = (m == RMODE_ZERO) || (m == RMODE_MINUS && !s) || (m == RMODE_PLUS && s);
    if (!big) return {s, EXT_EXP_INF, MANT_INF};
    return sgl ? {s, LGST_EXP_SGL, MANT_ONES_SGL} : {s, LGST_EXP_EXT, MANT_ONES_EXT};
  endfunction
  // ======
  initial begin
    {opValid, exClr, operrEn, ovflEn, inexEn, inexIn, inexRes, miscompares, cmp_count} = '0;
    op = '0;
    rMode = RMODE_NEAREST;
    rPrec = PREC_EXT;
    issueDelay = 4'h2;
    void'($urandom(13462));
    rst = 1'b1;
    tick(20);
    rst = 1'b0;
    newOp(DEST_FPREG, FMT_EXT);
    op.operand_error_flag = 1'b1;
    runOp(2);
    chk80(destValue_r, QNAN_ALL_ONES);
    chk32(32'(opErrF), 1);
    chk32(seenPre + seenPost, 0);
    operrEn = 1'b1;
    runOp(9);
    chk32(seenDest, 0);
    chk32(seenPre, 1);
    chk32(32'(tgt), 32'(TGT_USER_OPERAND_ERROR_FLAG));
    operrEn = 1'b0;
    for (int i = 0; i < 6; i++) begin
      newOp(DEST_INTREG, i < 2 ? FMT_BYTE : (i < 4 ? FMT_WORD : FMT_LONG));
      op.convMostNeg = i[0];
      op.convTooLarge = (i == 2);
      op.convInf = ~i[0] & (i != 2);
      runOp(2 + i);
      chk32(seenPost, 1);
      chk32(32'(excKind_r), 32'(EXC_CONV));
      chk32(intValue_r, intExp(op.destFmt, op.sign | i[0]));
      chk32(seenInt, 1);
    end
    for (int m = 0; m < 4; m++) begin
      newOp(DEST_FPREG, FMT_EXT);
      op.exp = EXP_MAX_EXT;
      rMode = fxo_rmode_type'(m);
      ovflEn = (m == 3);
      inexEn = (m != 2);
      inexIn = (m == 2);
      inexRes = (m == 1);
      runOp($urandom_range(6, 2));
      chk32(32'(ovF), 1);
      chk32(seenPre, 1);
      chk32(seenGo, 1);
      chk32(32'(tgt), m == 3 ? 32'd3 : 32'(m == 1));
      if (m != 3) begin
        chk80(destValue_r, ovExp(op.sign, rMode, 1'b0));
      end
    end
    newOp(DEST_FPREG, FMT_EXT);
    op.exp = EXP_MAX_EXT - 16'sh0001;
    runOp(2);
    chk32(32'(ovF), 0);
    op.roundCarry = 1'b1;
    runOp(3);
    chk32(32'(ovF), 1);
    newOp(DEST_MEM, FMT_SGL);
    op.moveOut = 1'b1;
    op.exp = EXP_MAX_SGL;
    rMode = RMODE_ZERO;
    runOp(3);
    chk32(seenPost, 1);
    chk32(frameEa_r, op.effAddr);
    chk32(32'(eaValid), 1);
    chk80(destValue_r, ovExp(op.sign, RMODE_ZERO, 1'b1));
    newOp(DEST_MEM, FMT_PACK);
    op.exp = EXP_MAX_EXT;
    runOp(2);
    chk32(32'({ovF, opErrF}), 1);
    newOp(DEST_FPREG, FMT_EXT);
    op.depMove = 1'b1;
    op.exp = EXP_MAX_EXT;
    runOp(2);
    chk32(seenPost, 1);
    chk32(32'(eaValid), 0);
    chk32(32'(imValid), 1);
    newOp(DEST_INTREG, FMT_WORD);
    op.convNan = 1'b1;
    runOp(2);
    chk32(seenPost, 1);
    chk32(seenInt, 0);
    newOp(DEST_INTREG, FMT_SGL);
    op.forced = 1'b1;
    op.forcedSel = PREC_DBL;
    op.expFamily = 1'b1;
    op.exp = EXP_MAX_DBL;
    runOp(2);
    chk32(seenPost, 1);
    chk32(iaddr, op.instrAddr);
    chk32(32'(imValid), 0);
    chk80(destValue_r, {op.sign, LGST_EXP_DBL, MANT_ONES_DBL});
    newOp(DEST_FPREG, FMT_EXT);
    op.exp = EXP_MIN_EXT;
    runOp(2);
    chk32(32'(unF), 1);
    chk32(32'(ovF), 0);
    stop_test();
  end
endmodule // fxo_exc_unit_tb
